// ==== include/dcr_params.svh ====
// Purpose: Constants for the clock, reset and audio input front end
// Assumes: 100 MHz system clock
// Notes: Counts are derived from times where a time is given
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH
`define DCR_INIT_CYCLES 11'd1024
`define DCR_RATIO_128 3'd0
`define DCR_RATIO_192 3'd1
`define DCR_RATIO_256 3'd2
`define DCR_RATIO_384 3'd3
`define DCR_RATIO_512 3'd4
`define DCR_RATIO_768 3'd5
`define DCR_FMT_I2S24 3'd4
`define DCR_SLIP_BITS 4'd6
`define DCR_BPZ_SAMPLE 24'h000000
`endif

// ==== include/dcr_pkg.sv ====
// Purpose: Types for the clock, reset and audio input front end
// Assumes: Nothing
// Notes: State codes are one-hot
package dcr_pkg;
    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_RUN = 3'b010,
        ST_RESYNC = 3'b100
    } dcr_state_e;
    typedef logic [23:0] dcr_sample_t;
endpackage

// ==== include/dcr_sync_if.sv ====
// Purpose: Synchronised pin levels passed from the sampler to the core
// Assumes: All signals on SYS_CLK
// Notes: None
`timescale 1ns/1ns
`default_nettype none
interface dcr_sync_if;
    logic audio_bit_clock;
    logic word_select_clock;
    logic data;
    logic rst_n;
    modport src (output audio_bit_clock, output word_select_clock, output data, output rst_n);
    modport dst (input audio_bit_clock, input word_select_clock, input data, input rst_n);
endinterface
`default_nettype wire

// ==== rtl/dcr_sync.sv ====
// Purpose: Two-stage synchronisers for the audio and reset pins
// Assumes: Pins asynchronous to SYS_CLK
// Notes: First stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module dcr_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins
    input wire logic bck_pin,
    input wire logic word_select_clock_pin,
    input wire logic data_pin,
    input wire logic rst_n_pin,
    // Synchronised levels
    dcr_sync_if.src so
);
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s1_next;
    logic [3:0] s2_next;

    always_comb begin
        s1_next = {rst_n_pin, data_pin, word_select_clock_pin, bck_pin};
        s2_next = s1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign so.audio_bit_clock = s2_reg[0];
    assign so.word_select_clock = s2_reg[1];
    assign so.data = s2_reg[2];
    assign so.rst_n = s2_reg[3];
endmodule
`default_nettype wire

// ==== rtl/dcr_top.sv ====
// Purpose: Clock ratio detect, reset sequencing and serial audio input
// Assumes: SYS_CLK is the converter system clock; link pins are sampled
// Notes:
`timescale 1ns/1ns
`default_nettype none
`include "dcr_params.svh"
module dcr_top #(
    parameter int INIT_CYCLES = 1024
) (
    // System
    input wire logic SYS_CLK,
    input wire logic RST,
    // Audio link
    input wire logic AUDIO_BIT_CLOCK,
    input wire logic WORD_SELECT_CLOCK,
    input wire logic AUDIO_DATA,
    input wire logic EXT_RESET_N,
    // Control port select and readback
    input wire logic CONTROL_PORT_SELECT,
    input wire logic READBACK_DATA,
    output logic CONTROL_READBACK_OUT,
    output logic CONTROL_READBACK_OE_N,
    // Status and samples
    output logic [2:0] CLOCK_RATIO,
    output logic [2:0] AUDIO_FORMAT_FIELD,
    output logic RUNNING,
    output logic [23:0] LEFT_SAMPLE,
    output logic [23:0] RIGHT_SAMPLE,
    output logic SAMPLE_VALID
);
    dcr_sync_if sy();
    dcr_pkg::dcr_state_e state_reg, state_next;
    logic [10:0] init_cnt_reg, init_cnt_next;
    logic bck_d_reg, word_select_clock_d_reg, rstn_d_reg;
    logic [9:0] per_cnt_reg, per_cnt_next;
    logic [9:0] per_ref_reg, per_ref_next;
    logic [2:0] ratio_reg, ratio_next;
    logic [2:0] fmt_reg, fmt_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] bck_per_reg, bck_per_next;
    logic [7:0] bck_cnt_reg, bck_cnt_next;
    logic [23:0] shift_reg, shift_next;
    logic [23:0] left_reg, left_next, right_reg, right_next;
    logic valid_reg, valid_next;
    logic lr_edge, bck_rise, rst_rise, slip;
    logic [10:0] init_last;
    logic sel_s1_reg, sel_s2_reg;

    dcr_sync u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .bck_pin(AUDIO_BIT_CLOCK),
        .word_select_clock_pin(WORD_SELECT_CLOCK),
        .data_pin(AUDIO_DATA),
        .rst_n_pin(EXT_RESET_N),
        .so(sy.src)
    );

    // Nearest supported ratio from clocks per word period
    function automatic logic [2:0] pick_ratio(input logic [9:0] n);
        if (n < 10'd160) pick_ratio = `DCR_RATIO_128;
        else if (n < 10'd224) pick_ratio = `DCR_RATIO_192;
        else if (n < 10'd320) pick_ratio = `DCR_RATIO_256;
        else if (n < 10'd448) pick_ratio = `DCR_RATIO_384;
        else if (n < 10'd640) pick_ratio = `DCR_RATIO_512;
        else pick_ratio = `DCR_RATIO_768;
    endfunction

    function automatic logic [9:0] absdiff(input logic [9:0] a, input logic [9:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    assign init_last = 11'(INIT_CYCLES - 1);
    assign bck_rise = sy.audio_bit_clock & ~bck_d_reg;
    assign lr_edge = sy.word_select_clock ^ word_select_clock_d_reg;
    assign rst_rise = sy.rst_n & ~rstn_d_reg;
    // Period change in system clocks beyond six bit clocks
    assign slip = lr_edge && sy.word_select_clock && (per_ref_reg != 10'h0)
        && (absdiff(per_cnt_reg, per_ref_reg) > 10'(bck_per_reg * `DCR_SLIP_BITS));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and ratio detect
    always_comb begin
        state_next = state_reg;
        init_cnt_next = init_cnt_reg;
        fmt_next = fmt_reg;
        per_cnt_next = (per_cnt_reg == 10'h3ff) ? per_cnt_reg : per_cnt_reg + 10'h1;
        per_ref_next = per_ref_reg;
        ratio_next = ratio_reg;
        bck_cnt_next = (bck_cnt_reg == 8'hff) ? bck_cnt_reg : bck_cnt_reg + 8'h1;
        bck_per_next = bck_per_reg;
        if (bck_rise) begin
            bck_per_next = bck_cnt_reg;
            bck_cnt_next = 8'h1;
        end
        if (lr_edge && sy.word_select_clock) begin
            per_cnt_next = 10'h1;
            per_ref_next = per_cnt_reg;
            if (per_cnt_reg != per_ref_reg)
                ratio_next = pick_ratio(per_cnt_reg);
        end
        case (state_reg)
            dcr_pkg::ST_INIT: begin
                init_cnt_next = init_cnt_reg + 11'h1;
                if (init_cnt_reg == init_last) begin
                    state_next = dcr_pkg::ST_RUN;
                    fmt_next = `DCR_FMT_I2S24;
                end
            end
            dcr_pkg::ST_RUN: begin
                if (slip) begin
                    state_next = dcr_pkg::ST_RESYNC;
                    init_cnt_next = 11'h0;
                end
            end
            dcr_pkg::ST_RESYNC: begin
                // Leave once a full period is within six bit clocks of the last one
                if (lr_edge && sy.word_select_clock && !slip && per_ref_reg != 10'h0)
                    state_next = dcr_pkg::ST_RUN;
            end
            default: state_next = dcr_pkg::ST_INIT;
        endcase
        if (!sy.rst_n || rst_rise) begin
            state_next = dcr_pkg::ST_INIT;
            init_cnt_next = 11'h0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= dcr_pkg::ST_INIT;
            init_cnt_reg <= 11'h0;
            fmt_reg <= `DCR_FMT_I2S24;
            per_cnt_reg <= 10'h0;
            per_ref_reg <= 10'h0;
            ratio_reg <= `DCR_RATIO_256;
            bck_cnt_reg <= 8'h0;
            bck_per_reg <= 8'h0;
            bck_d_reg <= 1'b0;
            word_select_clock_d_reg <= 1'b0;
            rstn_d_reg <= 1'b0;
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            init_cnt_reg <= init_cnt_next;
            fmt_reg <= fmt_next;
            per_cnt_reg <= per_cnt_next;
            per_ref_reg <= per_ref_next;
            ratio_reg <= ratio_next;
            bck_cnt_reg <= bck_cnt_next;
            bck_per_reg <= bck_per_next;
            bck_d_reg <= sy.audio_bit_clock;
            word_select_clock_d_reg <= sy.word_select_clock;
            rstn_d_reg <= sy.rst_n;
            sel_s1_reg <= CONTROL_PORT_SELECT;
            sel_s2_reg <= sel_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I2S receiver, one bit delay after word clock edge, MSB first
    always_comb begin
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        left_next = left_reg;
        right_next = right_reg;
        valid_next = 1'b0;
        if (lr_edge)
            bit_cnt_next = 5'h0;
        else if (bck_rise) begin
            if (bit_cnt_reg >= 5'd1 && bit_cnt_reg <= 5'd24)
                shift_next = {shift_reg[22:0], sy.data};
            if (bit_cnt_reg != 5'h1f)
                bit_cnt_next = bit_cnt_reg + 5'h1;
        end
        if (lr_edge && bit_cnt_reg >= 5'd25) begin
            if (sy.word_select_clock) left_next = shift_reg;
            else begin
                right_next = shift_reg;
                valid_next = 1'b1;
            end
        end
        if (state_reg != dcr_pkg::ST_RUN) begin
            left_next = `DCR_BPZ_SAMPLE;
            right_next = `DCR_BPZ_SAMPLE;
            valid_next = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            shift_reg <= 24'h0;
            bit_cnt_reg <= 5'h1f;
            left_reg <= 24'h0;
            right_reg <= 24'h0;
            valid_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            left_reg <= left_next;
            right_reg <= right_next;
            valid_reg <= valid_next;
        end
    end

    // Readback pin: open-drain drives low only when two-wire is selected
    // Select pin is a strap from outside, read only after two flops
    assign CONTROL_READBACK_OUT = sel_s2_reg ? 1'b0 : READBACK_DATA;
    assign CONTROL_READBACK_OE_N = sel_s2_reg ? READBACK_DATA : 1'b0;
    assign CLOCK_RATIO = ratio_reg;
    assign AUDIO_FORMAT_FIELD = fmt_reg;
    assign RUNNING = (state_reg == dcr_pkg::ST_RUN);
    assign LEFT_SAMPLE = left_reg;
    assign RIGHT_SAMPLE = right_reg;
    assign SAMPLE_VALID = valid_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_init_len;
        @(posedge SYS_CLK) disable iff (RST)
        (state_reg == dcr_pkg::ST_INIT && init_cnt_reg == 11'h0 && sy.rst_n && !rst_rise)
            |-> !RUNNING [*8];
    endproperty
    a_init_len: assert property (p_init_len) else $error("init too short");
    property p_rst_hold;
        @(posedge SYS_CLK) disable iff (RST) !sy.rst_n |=> !RUNNING;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("run during reset");
    property p_fmt_def;
        @(posedge SYS_CLK) disable iff (RST)
        ($past(state_reg) == dcr_pkg::ST_INIT && RUNNING) |-> fmt_reg == `DCR_FMT_I2S24;
    endproperty
    a_fmt_def: assert property (p_fmt_def) else $error("format not default");
    property p_slip;
        @(posedge SYS_CLK) disable iff (RST)
        (RUNNING && slip && sy.rst_n && !rst_rise) |=> !RUNNING ##1 LEFT_SAMPLE == 24'h0;
    endproperty
    a_slip: assert property (p_slip) else $error("no resync on slip");
    property p_bpz;
        @(posedge SYS_CLK) disable iff (RST)
        $past(!RUNNING) |-> (LEFT_SAMPLE == 24'h0 && RIGHT_SAMPLE == 24'h0 && !SAMPLE_VALID);
    endproperty
    a_bpz: assert property (p_bpz) else $error("outputs not zero");
    property p_shift;
        @(posedge SYS_CLK) disable iff (RST)
        (bck_rise && !lr_edge && bit_cnt_reg == 5'd3) |=> shift_reg[0] == $past(sy.data);
    endproperty
    a_shift: assert property (p_shift) else $error("bit not shifted");
    property p_od;
        @(posedge SYS_CLK) disable iff (RST)
        sel_s2_reg |-> (CONTROL_READBACK_OUT == 1'b0);
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_pp;
        @(posedge SYS_CLK) disable iff (RST)
        !sel_s2_reg |-> (!CONTROL_READBACK_OE_N && CONTROL_READBACK_OUT == READBACK_DATA);
    endproperty
    a_pp: assert property (p_pp) else $error("push pull not driven");
    property p_ratio;
        @(posedge SYS_CLK) disable iff (RST)
        (lr_edge && sy.word_select_clock && per_cnt_reg != per_ref_reg) |=> CLOCK_RATIO == pick_ratio($past(per_cnt_reg));
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio not chosen");
    c_run: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(RUNNING));
    c_valid: cover property (@(posedge SYS_CLK) disable iff (RST) SAMPLE_VALID);
    c_resync: cover property (@(posedge SYS_CLK) disable iff (RST) state_reg == dcr_pkg::ST_RESYNC);
endmodule
`default_nettype wire

// ==== test/dcr_audio_src.sv ====
// Purpose: Serial audio source model, I2S framing with 24-bit words
// Assumes: Bit clock period 80 ns; frames start off the system clock edge
// Notes: Bit clock stands low between frames; data toggles outside word bits
`timescale 1ns/1ns
`default_nettype none
module dcr_audio_src (
    // Serial link
    output logic audio_bit_clock,
    output logic word_select_clock,
    output logic data
);
    initial begin
        audio_bit_clock = 1'b0;
        word_select_clock = 1'b0;
        data = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One stereo frame, n bit clocks per word, timed by fixed 40 ns delays
    task automatic frame(input logic [23:0] l, input logic [23:0] r, input int n);
        logic [23:0] w;
        for (int ch = 0; ch < 2; ch++) begin
            w = (ch == 0) ? l : r;
            for (int i = 0; i < n; i++) begin
                audio_bit_clock = 1'b0;
                if (i == 0) begin
                    word_select_clock = ch[0];
                end
                // One bit late, MSB first, filler beyond the word
                data = (i >= 1 && i <= 24) ? w[24 - i] : ~data;
                #40;
                audio_bit_clock = 1'b1;
                #40;
            end
        end
        audio_bit_clock = 1'b0;
        data = ~data;
    endtask
endmodule
`default_nettype wire

// ==== test/dcr_top_tb.sv ====
// Purpose: Self-checking bench for the clock, reset and audio input front end
// Assumes: Short init count; bit clock 80 ns, so a frame of 2n bits is 16n clocks
// Notes: Rows cover ratio detect and sample capture; slips and resets by hand
`timescale 1ns/1ns
`default_nettype none
`include "dcr_params.svh"
module dcr_top_tb;
    localparam int INIT = 16;
    typedef struct {int n; logic [23:0] l; logic [23:0] r; logic [2:0] ratio;} dcr_row_s;
    // Ratios kept at 384 and above, no excluded rate pairs
    dcr_row_s rows [3] = '{'{32, 24'h800001, 24'h123456, `DCR_RATIO_512},
                           '{48, 24'h7ffffe, 24'hedcba9, `DCR_RATIO_768},
                           '{25, 24'h5a5a5a, 24'ha5a5a5, `DCR_RATIO_384}};
    logic sys_clk, rst, ext_rst_n, sel, rb_data, audio_bit_clock, word_select_clock, data;
    logic rb_out, rb_oe_n, running, valid, drop_seen, zero_bad, run_d;
    logic [2:0] ratio, fmt;
    logic [23:0] left, right, cap_l, cap_r;
    int n_fail, checks, n_valid, t0;

    dcr_audio_src src (.audio_bit_clock(audio_bit_clock), .word_select_clock(word_select_clock), .data(data));
    dcr_top #(.INIT_CYCLES(INIT)) dut (.SYS_CLK(sys_clk), .RST(rst),
        .AUDIO_BIT_CLOCK(audio_bit_clock), .WORD_SELECT_CLOCK(word_select_clock), .AUDIO_DATA(data),
        .EXT_RESET_N(ext_rst_n), .CONTROL_PORT_SELECT(sel), .READBACK_DATA(rb_data),
        .CONTROL_READBACK_OUT(rb_out), .CONTROL_READBACK_OE_N(rb_oe_n),
        .CLOCK_RATIO(ratio), .AUDIO_FORMAT_FIELD(fmt), .RUNNING(running),
        .LEFT_SAMPLE(left), .RIGHT_SAMPLE(right), .SAMPLE_VALID(valid));

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Captures stored pairs and watches outputs while not running
    always @(posedge sys_clk) begin
        #1;
        if (valid === 1'b1) begin
            n_valid++;
            cap_l = left;
            cap_r = right;
        end
        if (running !== 1'b1) begin
            drop_seen = 1'b1;
        end
        // Samples clear one clock after running drops
        if (rst === 1'b0 && running !== 1'b1 && run_d !== 1'b1) begin
            if (left !== 24'h000000 || right !== 24'h000000) begin
                zero_bad = 1'b1;
            end
        end
        run_d = running;
    end

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Counts clocks from a release until running, then checks the span
    task automatic init_span(input string name);
        t0 = 0;
        while (running !== 1'b1 && t0 < 200) begin
            @(posedge sys_clk);
            #2;
            t0++;
        end
        chk(name, 24'h1, {23'h0, t0 >= INIT && t0 <= INIT + 8});
        chk("fmt_default", {21'h0, `DCR_FMT_I2S24}, {21'h0, fmt});
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #600000;
        n_fail++;
        $display("watchdog expired");
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        ext_rst_n = 1'b1;
        sel = 1'b0;
        rb_data = 1'b0;
        n_fail = 0;
        checks = 0;
        n_valid = 0;
        drop_seen = 1'b0;
        zero_bad = 1'b0;
        repeat (5) @(posedge sys_clk);
        #2;
        chk("ratio_rst", {21'h0, `DCR_RATIO_256}, {21'h0, ratio});
        chk("run_rst", 24'h0, {23'h0, running});
        rst = 1'b0;
        init_span("init_after_rst");
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            sel = k[1];
            rb_data = k[0];
            repeat (2) @(posedge sys_clk);
            #2;
            chk("rb_out", {23'h0, sel ? 1'b0 : rb_data}, {23'h0, rb_out});
            chk("rb_oe_n", {23'h0, sel ? rb_data : 1'b0}, {23'h0, rb_oe_n});
        end
        @(posedge sys_clk);
        #2;
        $display("test readback done");
        foreach (rows[i]) begin
            repeat (4) src.frame(rows[i].l, rows[i].r, rows[i].n);
            n_valid = 0;
            repeat (2) src.frame(rows[i].l, rows[i].r, rows[i].n);
            chk("valid_seen", 24'h1, {23'h0, n_valid >= 1});
            chk("left", rows[i].l, cap_l);
            chk("right", rows[i].r, cap_r);
            chk("ratio", {21'h0, rows[i].ratio}, {21'h0, ratio});
            chk("running", 24'h1, {23'h0, running});
        end
        $display("test stream rows done");
        ext_rst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        #2;
        chk("run_in_ext_rst", 24'h0, {23'h0, running});
        ext_rst_n = 1'b1;
        init_span("init_after_ext");
        $display("test external reset done");
        repeat (4) src.frame(24'h111111, 24'heeeeee, 32);
        drop_seen = 1'b0;
        src.frame(24'h111111, 24'heeeeee, 37);
        repeat (3) src.frame(24'h111111, 24'heeeeee, 32);
        chk("no_drop_small_slip", 24'h0, {23'h0, drop_seen});
        src.frame(24'h222222, 24'hdddddd, 40);
        src.frame(24'h222222, 24'hdddddd, 32);
        chk("drop_big_slip", 24'h1, {23'h0, drop_seen});
        repeat (4) src.frame(24'h333333, 24'hcccccc, 32);
        chk("resync_running", 24'h1, {23'h0, running});
        chk("resync_left", 24'h333333, cap_l);
        chk("zero_while_down", 24'h0, {23'h0, zero_bad});
        $display("test slip done");
        end_of_test;
    end
endmodule
`default_nettype wire
